// >>> inc/fp_status_pkg.sv
// fp status/control register package: field positions, codes, reset values
// assumes: single processor clock, ports carried as packed structs
package fp_status_pkg;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int RdLsb    = 30;
    localparam int TemLsb   = 23;
    localparam int NstdBit  = 22;
    localparam int VerLsb   = 17;
    localparam int FttLsb   = 14;
    localparam int FccLsb   = 10;
    localparam int AexcLsb  = 5;
    localparam int CexcLsb  = 0;

    // ------------------------------------------------------------------
    // codes and reset values
    // ------------------------------------------------------------------
    localparam logic [1:0] RndNearest = 2'h0;
    localparam logic [1:0] RndZero    = 2'h1;
    localparam logic [1:0] RndPosInf  = 2'h2;
    localparam logic [1:0] RndNegInf  = 2'h3;
    localparam logic [2:0] FttNone    = 3'h0;
    localparam logic [2:0] FttIeee    = 3'h1;
    localparam logic [2:0] FttSeqErr  = 3'h4;
    localparam logic [1:0] FccEqual   = 2'h0;
    localparam logic [1:0] FccLess    = 2'h1;
    localparam logic [1:0] FccGreater = 2'h2;
    localparam logic [1:0] FccUnord   = 2'h3;
    localparam logic [1:0] RdReset    = 2'h0;
    localparam logic [4:0] TemReset   = 5'h00;
    localparam logic [1:0] FccReset   = 2'h0;
    localparam logic [4:0] ExcReset   = 5'h00;
    // version code, value arbitrary
    localparam logic [2:0] FpuVersion = 3'h0;

    typedef enum logic [1:0] {
        OP_ARITH,
        OP_COMPARE,
        OP_SEQ_ERR
    } fp_op_kind_t;

    // completion report from the fp datapath
    typedef struct packed {
        logic        done;
        fp_op_kind_t kind;
        logic [4:0]  exc;
        logic [1:0]  cmpResult;
    } fp_result_t;

    // load/store of the whole register by the integer pipeline
    typedef struct packed {
        logic        load;
        logic        store;
        logic [31:0] data;
    } status_access_t;

endpackage

// >>> src/fp_status_trap_control.sv
// fp status/control register with trap decision and exception accrual
// assumes: datapath reports one completion pulse per operation, same clock
`timescale 1ns/100ps

// Behaviour
// - two-bit rounding field drives roundMode: nearest, zero, plus, minus infinity
// - five trap-enable bits, one per exception kind, gate trapping
// - non-standard mode bit always reads zero
// - trap type loaded on exception, held until store or next operation; register loads also overwrite it
// - condition codes change only on compare instructions and register loads
// - branch-taken decisions use the current condition codes
// - mask AND current flags nonzero raises fp_exception trap
// - masked result zero ORs current flags into accrued field
// - current flags set for occurred exceptions, cleared otherwise
// - register readable after power-up; fields get reset values
// - register loaded and stored by non-privileged load/store instructions
// - trap type: 0 none, 1 IEEE exception, 4 sequence error
// - compare codes: 0 equal, 1 less, 2 greater, 3 unordered
// - condition codes unchanged when a compare traps
module fp_status_trap_control (
    input  wire logic                          ref_clk,
    input  wire logic                          resetn,
    input  wire fp_status_pkg::fp_result_t     result,
    input  wire fp_status_pkg::status_access_t access,
    input  wire logic [3:0]                    branchCond,
    output logic [31:0]                        statusReadData,
    output logic [1:0]                         roundMode,
    output logic                               fpTrap,
    output logic                               branchTaken
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    logic [1:0]  rd_r,   rd_nxt;
    logic [4:0]  tem_r,  tem_nxt;
    logic [2:0]  ftt_r,  ftt_nxt;
    logic [1:0]  fcc_r,  fcc_nxt;
    logic [4:0]  aexc_r, aexc_nxt;
    logic [4:0]  cexc_r, cexc_nxt;
    logic        trap_r, trap_nxt;
    logic        taken_r, taken_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic        trapHit;

    // full register image, reserved and non-standard bits zero
    function automatic logic [31:0] packStatus(
        input logic [1:0] rd, input logic [4:0] tem, input logic [2:0] ftt,
        input logic [1:0] fcc, input logic [4:0] aexc, input logic [4:0] cexc);
        logic [31:0] v;
        v = 32'h0000_0000;
        v[fp_status_pkg::RdLsb +: 2]   = rd;
        v[fp_status_pkg::TemLsb +: 5]  = tem;
        v[fp_status_pkg::NstdBit]      = 1'b0;
        v[fp_status_pkg::VerLsb +: 3]  = fp_status_pkg::FpuVersion;
        v[fp_status_pkg::FttLsb +: 3]  = ftt;
        v[fp_status_pkg::FccLsb +: 2]  = fcc;
        v[fp_status_pkg::AexcLsb +: 5] = aexc;
        v[fp_status_pkg::CexcLsb +: 5] = cexc;
        return v;
    endfunction

    // ------------------------------------------------------------------
    // next-state: operations, loads, stores
    // ------------------------------------------------------------------
    always_comb begin
        rd_nxt   = rd_r;
        tem_nxt  = tem_r;
        ftt_nxt  = ftt_r;
        fcc_nxt  = fcc_r;
        aexc_nxt = aexc_r;
        cexc_nxt = cexc_r;
        trap_nxt = 1'b0;
        trapHit  = |(tem_r & result.exc);
        if (result.done) begin
            cexc_nxt = result.exc;
            ftt_nxt  = fp_status_pkg::FttNone;
            case (result.kind)
                fp_status_pkg::OP_SEQ_ERR: begin
                    ftt_nxt  = fp_status_pkg::FttSeqErr;
                    cexc_nxt = cexc_r;
                    trap_nxt = 1'b1;
                end
                fp_status_pkg::OP_ARITH,
                fp_status_pkg::OP_COMPARE: begin
                    if (trapHit) begin
                        ftt_nxt  = fp_status_pkg::FttIeee;
                        trap_nxt = 1'b1;
                    end else begin
                        aexc_nxt = aexc_r | result.exc;
                    end
                    if (result.kind == fp_status_pkg::OP_COMPARE && !trapHit) begin
                        fcc_nxt = result.cmpResult;
                    end
                end
                default: begin
                    cexc_nxt = cexc_r;
                end
            endcase
        end else if (access.load) begin
            // version and reserved bits are dropped
            rd_nxt   = access.data[fp_status_pkg::RdLsb +: 2];
            tem_nxt  = access.data[fp_status_pkg::TemLsb +: 5];
            ftt_nxt  = access.data[fp_status_pkg::FttLsb +: 3];
            fcc_nxt  = access.data[fp_status_pkg::FccLsb +: 2];
            aexc_nxt = access.data[fp_status_pkg::AexcLsb +: 5];
            cexc_nxt = access.data[fp_status_pkg::CexcLsb +: 5];
        end else if (access.store) begin
            ftt_nxt = fp_status_pkg::FttNone;
        end
    end

    // store data captured before the store clears the trap type
    always_comb begin
        rdata_nxt = rdata_r;
        if (access.store) begin
            rdata_nxt = packStatus(rd_r, tem_r, ftt_r, fcc_r, aexc_r, cexc_r);
        end
    end

    // ------------------------------------------------------------------
    // branch decision: branchCond bit i taken when fcc == i
    // ------------------------------------------------------------------
    always_comb begin
        taken_nxt = branchCond[fcc_r];
    end

    // status fields and trap pulse, defined reset values
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            rd_r    <= fp_status_pkg::RdReset;
            tem_r   <= fp_status_pkg::TemReset;
            ftt_r   <= fp_status_pkg::FttNone;
            fcc_r   <= fp_status_pkg::FccReset;
            aexc_r  <= fp_status_pkg::ExcReset;
            cexc_r  <= fp_status_pkg::ExcReset;
            trap_r  <= 1'b0;
        end else begin
            rd_r    <= rd_nxt;
            tem_r   <= tem_nxt;
            ftt_r   <= ftt_nxt;
            fcc_r   <= fcc_nxt;
            aexc_r  <= aexc_nxt;
            cexc_r  <= cexc_nxt;
            trap_r  <= trap_nxt;
        end
    end

    // store snapshot register
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            rdata_r <= 32'h0000_0000;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    // branch decision register
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            taken_r <= 1'b0;
        end else begin
            taken_r <= taken_nxt;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign roundMode      = rd_r;
    assign fpTrap         = trap_r;
    assign branchTaken    = taken_r;
    assign statusReadData = rdata_r;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    a_trap_on_mask: assert property (@(posedge ref_clk) disable iff (!resetn)
        result.done && result.kind != fp_status_pkg::OP_SEQ_ERR
            && |(tem_r & result.exc) |=> fpTrap && ftt_r == fp_status_pkg::FttIeee)
        else $error("masked exception did not trap");
    a_accrue_flags: assert property (@(posedge ref_clk) disable iff (!resetn)
        result.done && result.kind == fp_status_pkg::OP_ARITH
            && !(|(tem_r & result.exc)) |=> aexc_r == ($past(aexc_r) | $past(result.exc)))
        else $error("accrued flags not updated");
    a_cexc_replace: assert property (@(posedge ref_clk) disable iff (!resetn)
        result.done && result.kind != fp_status_pkg::OP_SEQ_ERR
            |=> cexc_r == $past(result.exc))
        else $error("current flags wrong");
    a_fcc_hold: assert property (@(posedge ref_clk) disable iff (!resetn)
        !(result.done && result.kind == fp_status_pkg::OP_COMPARE) && !access.load
            |=> $stable(fcc_r))
        else $error("condition codes changed without compare");
    a_fcc_trap: assert property (@(posedge ref_clk) disable iff (!resetn)
        fpTrap && $past(result.kind) == fp_status_pkg::OP_COMPARE |-> $stable(fcc_r))
        else $error("trapping compare changed codes");
    a_nonstd_zero: assert property (@(posedge ref_clk) disable iff (!resetn)
        statusReadData[fp_status_pkg::NstdBit] == 1'b0)
        else $error("non-standard mode bit reads one");
    a_ver_fixed: assert property (@(posedge ref_clk) disable iff (!resetn)
        access.store ##1 1'b1 |-> statusReadData[fp_status_pkg::VerLsb +: 3]
            == fp_status_pkg::FpuVersion)
        else $error("version field altered");
    a_store_clears: assert property (@(posedge ref_clk) disable iff (!resetn)
        access.store && !access.load && !result.done
            |=> ftt_r == fp_status_pkg::FttNone
            && statusReadData[fp_status_pkg::FttLsb +: 3] == $past(ftt_r))
        else $error("store did not return then clear trap type");
    a_branch_cond: assert property (@(posedge ref_clk) disable iff (!resetn)
        1'b1 |=> branchTaken == $past(branchCond[fcc_r]))
        else $error("branch decision wrong");

    // ------------------------------------------------------------------
    // check helpers, decoded apart from the register logic
    // ------------------------------------------------------------------
    // kinds that go through the IEEE trap decision
    function automatic logic ieeeKind(input fp_status_pkg::fp_op_kind_t k);
        return (k == fp_status_pkg::OP_ARITH) || (k == fp_status_pkg::OP_COMPARE);
    endfunction

    logic ieeeDone;
    logic ieeeTrap;
    logic ieeeClean;
    logic loadTaken;

    // qualified events as the checks see them
    assign ieeeDone  = result.done && ieeeKind(result.kind);
    assign ieeeTrap  = ieeeDone && (|(tem_r & result.exc));
    assign ieeeClean = ieeeDone && !(|(tem_r & result.exc));
    assign loadTaken = access.load && !result.done;

    // ------------------------------------------------------------------
    // checks on loads, trap decision, flags and snapshot
    // ------------------------------------------------------------------
    // rounding and mask fields move only on a taken load
    a_round_load: assert property (@(posedge ref_clk) disable iff (!resetn)
        loadTaken |=> roundMode == $past(access.data[fp_status_pkg::RdLsb +: 2]))
        else $error("rounding field not loaded");
    a_round_hold: assert property (@(posedge ref_clk) disable iff (!resetn)
        !loadTaken |=> $stable(roundMode))
        else $error("rounding field changed without load");
    a_tem_load: assert property (@(posedge ref_clk) disable iff (!resetn)
        loadTaken |=> tem_r == $past(access.data[fp_status_pkg::TemLsb +: 5]))
        else $error("trap mask not loaded");
    a_tem_hold: assert property (@(posedge ref_clk) disable iff (!resetn)
        !loadTaken |=> $stable(tem_r))
        else $error("trap mask changed without load");

    // remaining fields of a taken load
    a_fcc_load: assert property (@(posedge ref_clk) disable iff (!resetn)
        loadTaken |=> fcc_r == $past(access.data[fp_status_pkg::FccLsb +: 2]))
        else $error("condition codes not loaded");
    a_ftt_load: assert property (@(posedge ref_clk) disable iff (!resetn)
        loadTaken |=> ftt_r == $past(access.data[fp_status_pkg::FttLsb +: 3]))
        else $error("trap type not loaded");
    a_exc_load: assert property (@(posedge ref_clk) disable iff (!resetn)
        loadTaken |=> aexc_r == $past(access.data[fp_status_pkg::AexcLsb +: 5])
            && cexc_r == $past(access.data[fp_status_pkg::CexcLsb +: 5]))
        else $error("exception fields not loaded");

    // trap pulse only after a trapping completion
    a_no_trap_idle: assert property (@(posedge ref_clk) disable iff (!resetn)
        !result.done |=> !fpTrap)
        else $error("trap without completion");
    a_clean_no_trap: assert property (@(posedge ref_clk) disable iff (!resetn)
        ieeeClean |=> !fpTrap && ftt_r == fp_status_pkg::FttNone)
        else $error("unmasked-free completion trapped");
    a_seq_err_trap: assert property (@(posedge ref_clk) disable iff (!resetn)
        result.done && result.kind == fp_status_pkg::OP_SEQ_ERR
            |=> fpTrap && ftt_r == fp_status_pkg::FttSeqErr && $stable(cexc_r))
        else $error("sequence error not reported");

    // accrual and current flags
    a_trap_keeps_aexc: assert property (@(posedge ref_clk) disable iff (!resetn)
        ieeeTrap |=> $stable(aexc_r))
        else $error("trapping operation accrued flags");
    a_accrue_compare: assert property (@(posedge ref_clk) disable iff (!resetn)
        ieeeClean && result.kind == fp_status_pkg::OP_COMPARE
            |=> aexc_r == ($past(aexc_r) | $past(result.exc)))
        else $error("compare flags not accrued");
    a_cexc_hold: assert property (@(posedge ref_clk) disable iff (!resetn)
        !result.done && !access.load |=> $stable(cexc_r))
        else $error("current flags changed without operation");

    // compare result lands in the condition codes
    a_fcc_compare: assert property (@(posedge ref_clk) disable iff (!resetn)
        ieeeClean && result.kind == fp_status_pkg::OP_COMPARE
            |=> fcc_r == $past(result.cmpResult))
        else $error("compare code not stored");

    // trap type holds between operations, loads and stores
    a_ftt_hold: assert property (@(posedge ref_clk) disable iff (!resetn)
        !result.done && !access.load && !access.store |=> $stable(ftt_r))
        else $error("trap type changed on its own");

    // store snapshot matches every field but ftt and version, which are checked above, and holds otherwise
    a_store_image: assert property (@(posedge ref_clk) disable iff (!resetn)
        access.store |=> statusReadData[fp_status_pkg::RdLsb +: 2] == $past(rd_r)
            && statusReadData[fp_status_pkg::TemLsb +: 5] == $past(tem_r)
            && statusReadData[fp_status_pkg::FccLsb +: 2] == $past(fcc_r)
            && statusReadData[fp_status_pkg::AexcLsb +: 5] == $past(aexc_r)
            && statusReadData[fp_status_pkg::CexcLsb +: 5] == $past(cexc_r))
        else $error("store image wrong");
    a_read_hold: assert property (@(posedge ref_clk) disable iff (!resetn)
        !access.store |=> $stable(statusReadData))
        else $error("read data changed without store");

    // every field defined at the first edge after reset
    a_reset_values: assert property (@(posedge ref_clk)
        $rose(resetn) |-> roundMode == fp_status_pkg::RdReset
            && tem_r == fp_status_pkg::TemReset && ftt_r == fp_status_pkg::FttNone
            && fcc_r == fp_status_pkg::FccReset && aexc_r == fp_status_pkg::ExcReset
            && cexc_r == fp_status_pkg::ExcReset && !fpTrap)
        else $error("fields not at reset values");

endmodule

// >>> test/fp_pipe_model.sv
// far-side model: fp datapath completions and load/store requests
// assumes: shares ref_clk with the block; requests change 1 ns after an edge
`timescale 1ns/100ps
module fp_pipe_model (
    input  wire logic                          ref_clk,
    output var  fp_status_pkg::fp_result_t     result,
    output var  fp_status_pkg::status_access_t access
);
    // idle at time zero
    initial begin
        result = '0;
        access = '0;
    end

    // one completion pulse; stale flags do not linger after it
    task automatic complete(input fp_status_pkg::fp_op_kind_t k, input logic [4:0] e,
                            input logic [1:0] c);
        @(posedge ref_clk) #1;
        result = '{done: 1'b1, kind: k, exc: e, cmpResult: c};
        @(posedge ref_clk) #1;
        result.done = 1'b0;
        result.exc = ~e;
        result.cmpResult = ~c;
    endtask

    // non-privileged load or store of the whole register
    task automatic xfer(input logic ld, input logic [31:0] d);
        @(posedge ref_clk) #1;
        access = '{load: ld, store: ~ld, data: d};
        @(posedge ref_clk) #1;
        access = '{load: 1'b0, store: 1'b0, data: ~d};
    endtask
endmodule

// >>> test/tb.sv
// testbench: load/store and completion sequences with a shadow register image
// assumes: fp_pipe_model drives result and access, branchCond driven here
`timescale 1ns/100ps
module tb;
    logic                          ref_clk = 1'b0;
    logic                          resetn = 1'b0;
    logic [3:0]                    branchCond = 4'h0;
    fp_status_pkg::fp_result_t     result;
    fp_status_pkg::status_access_t access;
    logic [31:0]                   statusReadData;
    logic [1:0]                    roundMode;
    logic                          fpTrap;
    logic                          branchTaken;
    logic [1:0]                    rd, fcc;
    logic [4:0]                    tem, aexc, cexc;
    logic [2:0]                    ftt;
    int                            failures = 0;
    int                            num_checks = 0;

    // 250 MHz clock
    always #2 ref_clk = ~ref_clk;

    fp_pipe_model fp_pipe_model_i (.ref_clk(ref_clk), .result(result), .access(access));

    fp_status_trap_control fp_status_trap_control_i (
        .ref_clk(ref_clk), .resetn(resetn), .result(result), .access(access),
        .branchCond(branchCond), .statusReadData(statusReadData), .roundMode(roundMode),
        .fpTrap(fpTrap), .branchTaken(branchTaken));

    task automatic end_of_test();
        if (failures == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // store snapshot against the shadow image; store then clears trap type
    task automatic rdchk();
        fp_pipe_model_i.xfer(1'b0, 32'h0000_0000);
        check(statusReadData,
              (32'(rd) << fp_status_pkg::RdLsb) | (32'(tem) << fp_status_pkg::TemLsb)
              | (32'(fp_status_pkg::FpuVersion) << fp_status_pkg::VerLsb)
              | (32'(ftt) << fp_status_pkg::FttLsb) | (32'(fcc) << fp_status_pkg::FccLsb)
              | (32'(aexc) << fp_status_pkg::AexcLsb) | 32'(cexc));
        ftt = fp_status_pkg::FttNone;
    endtask

    task automatic ld(input logic [31:0] d);
        fp_pipe_model_i.xfer(1'b1, d);
        {rd, tem} = {d[31:30], d[27:23]};
        {fcc, aexc, cexc} = {d[11:10], d[9:5], d[4:0]};
        ftt = d[fp_status_pkg::FttLsb +: 3];
    endtask

    // completion, trap pulse checked in the cycle after, shadow updated
    task automatic op(input fp_status_pkg::fp_op_kind_t k, input logic [4:0] e,
                      input logic [1:0] c);
        logic trap;
        trap = (k == fp_status_pkg::OP_SEQ_ERR) || ((tem & e) != 5'h00);
        fp_pipe_model_i.complete(k, e, c);
        check(32'(fpTrap), 32'(trap));
        if (k == fp_status_pkg::OP_SEQ_ERR) begin
            ftt = fp_status_pkg::FttSeqErr;
        end else begin
            cexc = e;
            ftt = trap ? fp_status_pkg::FttIeee : fp_status_pkg::FttNone;
            if (!trap) begin
                aexc = aexc | e;
                if (k == fp_status_pkg::OP_COMPARE) fcc = c;
            end
        end
    endtask

    // main sequence
    initial begin
        {rd, tem, ftt, fcc, aexc, cexc} = '0;
        repeat (12) @(posedge ref_clk);
        #1 resetn = 1'b1;
        rdchk();
        for (int i = 0; i < 4; i++) begin
            ld({2'(i), 30'h3FFE_3FFF});
            check(32'(roundMode), 32'(i));
            rdchk();
        end
        ld(32'h0000_0000);
        op(fp_status_pkg::OP_ARITH, 5'h05, 2'h0);
        op(fp_status_pkg::OP_ARITH, 5'h02, 2'h0);
        rdchk();
        ld(32'h0800_0000);
        op(fp_status_pkg::OP_ARITH, 5'h11, 2'h0);
        @(posedge ref_clk) #1;
        check(32'(fpTrap), 32'h0000_0000);
        rdchk();
        rdchk();
        for (int i = 0; i < 4; i++) begin
            op(fp_status_pkg::OP_COMPARE, 5'h00, 2'(i));
            branchCond = ~(4'h1 << i);
            @(posedge ref_clk) #1;
            check(32'(branchTaken), 32'h0000_0000);
            branchCond = 4'h1 << i;
            @(posedge ref_clk) #1;
            check(32'(branchTaken), 32'h0000_0001);
        end
        op(fp_status_pkg::OP_ARITH, 5'h00, 2'h0);
        op(fp_status_pkg::OP_COMPARE, 5'h10, 2'h1);
        rdchk();
        op(fp_status_pkg::OP_SEQ_ERR, 5'h00, 2'h0);
        rdchk();
        // mid-run reset brings every field back to its reset value
        @(posedge ref_clk) #1 resetn = 1'b0;
        @(posedge ref_clk) #1 resetn = 1'b1;
        {rd, tem, ftt, fcc, aexc, cexc} = '0;
        rdchk();
        end_of_test();
    end

    // watchdog far beyond the 77 cycles needed
    initial begin
        #20000;
        failures++;
        end_of_test();
    end
endmodule
